// ---- hw/ups_pkg.sv ----
// Package of register map, field positions and reset values for the power/suspend block.
package ups_pkg;

    // ------------------------------------------------------------------
    // Register indices and byte addresses
    // ------------------------------------------------------------------
    localparam logic [5:0] REG_POWER_IDX    = 6'h01;  // Power-control register index.
    localparam logic [5:0] REG_FRAME_LO_IDX = 6'h0c;  // Frame count low byte index.
    localparam logic [5:0] REG_IRQ_STAT_IDX = 6'h10;  // Sticky event status, read only.
    localparam logic [5:0] REG_IRQ_CLR_IDX  = 6'h11;  // Write one to clear status.
    localparam logic [5:0] REG_IRQ_EN_IDX   = 6'h12;  // Event enable register.
    localparam int         ADDR_W           = 8;      // Byte address width.

    // ------------------------------------------------------------------
    // Power-control field positions
    // ------------------------------------------------------------------
    localparam int PWR_ISO_GATE  = 7;  // Iso frame gate enable.
    localparam int PWR_INHIBIT   = 4;  // Function inhibit.
    localparam int PWR_RESET     = 3;  // Read: bus reset seen. Write one: force reset.
    localparam int PWR_RESUME    = 2;  // Remote wakeup drive.
    localparam int PWR_SUSPENDED = 1;  // Suspended flag, read only.
    localparam int PWR_SUSP_EN   = 0;  // Suspend detect enable.

    // ------------------------------------------------------------------
    // Event bits shared by status, clear and enable registers
    // ------------------------------------------------------------------
    localparam int IRQ_W      = 3;  // Number of event bits.
    localparam int IRQ_WAKE   = 0;  // Resume signalling detected.
    localparam int IRQ_SLEEP  = 1;  // Suspend entered.
    localparam int IRQ_BUSRST = 2;  // Bus reset detected.

    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------
    localparam logic [7:0]       POWER_RST    = 8'h10;  // Inhibit set, all else clear.
    localparam logic [IRQ_W-1:0] IRQ_EN_RST   = 3'h5;   // Non-suspend events enabled.
    localparam logic [7:0]       FRAME_LO_RST = 8'h00;  // Frame count low byte.

endpackage

// ---- hw/ups_sync2.sv ----
// Two-flop synchroniser for bus line-state levels.
`timescale 1ns/1ns
module ups_sync2 #(
    parameter int W = 3  // Number of levels.
) (
    // Clock and reset
    input  wire logic         clk_i,
    input  wire logic         rst_i,
    // Levels from outside the clock domain
    input  wire logic [W-1:0] async_i,
    // Synchronised levels
    output logic      [W-1:0] sync_o
);

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [W-1:0] meta;  // First stage, read only by the second stage.
        logic [W-1:0] safe;  // Second stage.
    } ups_sync_t;

    ups_sync_t st_r;   // Registered state.
    ups_sync_t st_nxt; // Next state.

    // Shift the levels through the two stages.
    always_comb begin
        st_nxt      = st_r;
        st_nxt.meta = async_i;
        st_nxt.safe = st_r.meta;
    end

    // Register the stages; reset to idle lines.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign sync_o = st_r.safe;

endmodule

// ---- hw/ups_iso_gate.sv ----
// Holds newly loaded iso IN packets until the next start-of-frame.
`timescale 1ns/1ns
module ups_iso_gate #(
    parameter int N_EP = 3  // Number of iso IN endpoints.
) (
    // Clock and reset
    input  wire logic            clk_i,
    input  wire logic            rst_i,
    // Control
    input  wire logic            gate_en_i,
    input  wire logic            sof_i,
    // Endpoint events
    input  wire logic [N_EP-1:0] load_i,
    input  wire logic [N_EP-1:0] token_i,
    // Token answers, one-cycle pulses
    output logic      [N_EP-1:0] send_pkt_o,
    output logic      [N_EP-1:0] send_zlp_o
);

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [N_EP-1:0] pending;  // Loaded, waiting for a frame start.
        logic [N_EP-1:0] ready;    // Released for transmission.
        logic [N_EP-1:0] pkt;      // Answer with the packet.
        logic [N_EP-1:0] zlp;      // Answer with a zero-length packet.
    } ups_iso_t;

    ups_iso_t st_r;   // Registered state.
    ups_iso_t st_nxt; // Next state.

    // A token takes the packet only once it has been released.
    always_comb begin
        st_nxt     = st_r;
        st_nxt.pkt = token_i & st_r.ready;
        st_nxt.zlp = token_i & ~st_r.ready;
        st_nxt.ready = st_r.ready & ~token_i;
        if (gate_en_i) begin
            st_nxt.pending = st_r.pending | load_i;
            if (sof_i) begin
                st_nxt.ready   = st_nxt.ready | st_nxt.pending;
                st_nxt.pending = '0;
            end
        end else begin
            // Turning the gate off releases anything still held.
            st_nxt.ready   = st_nxt.ready | st_r.pending | load_i;
            st_nxt.pending = '0;
        end
    end

    // Register the state.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign send_pkt_o = st_r.pkt;
    assign send_zlp_o = st_r.zlp;

    // A token that finds nothing released gets a zero-length packet.
    chk_iso_zlp_answer: assert property (@(posedge clk_i) disable iff (rst_i)
        (token_i[0] && !st_r.ready[0]) |=> (send_zlp_o[0] && !send_pkt_o[0]))
        else $error("iso token before release did not get a zero-length packet");

endmodule

// ---- hw/ups_power_ctrl.sv ----
// Power, suspend, resume, inhibit and forced reset control with a Wishbone register slave.
//
// Summary of operation
// - Leave suspend on resume, bus reset, reset
// - Wake the oscillator whenever suspend is left
// - Resume detected: exit suspend, raise wake event if enabled
// - Resume bit while suspended drives resume signalling
// - Iso gate holds new IN packets until SOF
// - Early iso IN token gets zero-length packet
// - Function starts inhibited; clearing inhibit enables it
// - Inhibit returns only by power-on or forced reset
// - Inhibited function ignores all bus traffic
// - Writing reset bit forces whole-function reset
// - Reset bit reads bus reset signalling status
// - Enabled suspend detection enters suspend on signalling
// - Suspend entry raises sleep event if enabled
// - Bus reset clears address, endpoints, re-enables non-suspend events
// - Forced reset restores every register default
//
// Our own choice: the Wishbone slave port.
`timescale 1ns/1ns
module ups_power_ctrl
    import ups_pkg::*;
#(
    parameter int N_EP = 3  // Number of iso IN endpoints.
) (
    // Clock and reset
    input  wire logic              clk_i,
    input  wire logic              rst_i,
    // Wishbone slave
    input  wire logic              cyc_i,
    input  wire logic              stb_i,
    input  wire logic              we_i,
    input  wire logic [ADDR_W-1:0] adr_i,
    input  wire logic [3:0]        sel_i,
    input  wire logic [31:0]       dat_i,
    output logic      [31:0]       dat_o,
    output logic                   ack_o,
    // Bus line-state levels from the transceiver
    input  wire logic              line_suspend_i,
    input  wire logic              line_resume_i,
    input  wire logic              line_reset_i,
    // Packet engine events, same clock
    input  wire logic              sof_i,
    input  wire logic [N_EP-1:0]   iso_load_i,
    input  wire logic [N_EP-1:0]   iso_token_i,
    // Iso token answers
    output logic      [N_EP-1:0]   iso_send_pkt_o,
    output logic      [N_EP-1:0]   iso_send_zlp_o,
    // Function control
    output logic                   traffic_en_o,
    output logic                   suspended_o,
    output logic                   resume_drive_o,
    output logic                   osc_wake_o,
    output logic                   func_reset_o,
    output logic                   bus_reset_clear_o,
    // Interrupt
    output logic                   irq_o
);

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef struct packed {
        logic             iso_gate;    // Iso frame gate enable.
        logic             inhibit;     // Function inhibit.
        logic             resume_drv;  // Remote wakeup drive.
        logic             suspended;   // Suspended flag.
        logic             susp_en;     // Suspend detect enable.
        logic [IRQ_W-1:0] irq_stat;    // Sticky event status.
        logic [IRQ_W-1:0] irq_en;      // Event enables.
        logic [7:0]       frame_lo;    // Frame count low byte.
        logic [2:0]       line_d;      // Previous synchronised line levels.
        logic             ack;         // Bus acknowledge.
        logic [31:0]      rdata;       // Bus read data.
        logic             irq;         // Interrupt output.
        logic             osc_wake;    // Oscillator wake pulse.
        logic             func_rst;    // Forced function reset pulse.
        logic             bus_rst_clr; // Endpoint and address clear pulse.
        logic             traffic_en;  // Traffic enable, the inverse of inhibit.
    } ups_state_t;

    ups_state_t st_r;   // Registered state.
    ups_state_t st_nxt; // Next state.

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------

    // Default register contents, used at power-on and at forced reset.
    function automatic ups_state_t ups_default();
        ups_state_t d;
        d            = '0;
        d.iso_gate   = POWER_RST[PWR_ISO_GATE];
        d.inhibit    = POWER_RST[PWR_INHIBIT];
        d.resume_drv = POWER_RST[PWR_RESUME];
        d.suspended  = POWER_RST[PWR_SUSPENDED];
        d.susp_en    = POWER_RST[PWR_SUSP_EN];
        d.irq_en     = IRQ_EN_RST;
        d.frame_lo   = FRAME_LO_RST;
        d.traffic_en = !POWER_RST[PWR_INHIBIT];
        return d;
    endfunction

    // Byte address of a register index.
    function automatic logic [ADDR_W-1:0] ups_addr(input logic [5:0] idx);
        return {idx, 2'b00};
    endfunction

    // ------------------------------------------------------------------
    // Line-state synchronisation and edge detection
    // ------------------------------------------------------------------
    logic [2:0] line_s;     // Synchronised levels: reset, resume, suspend.
    logic       sus_rise;   // Suspend signalling begins.
    logic       res_rise;   // Resume signalling begins.
    logic       rst_rise;   // Bus reset signalling begins.
    logic       sof_ok;     // Frame start accepted.
    logic [N_EP-1:0] load_ok;  // Packet loads seen by the gate.
    logic [N_EP-1:0] token_ok; // Tokens accepted.

    ups_sync2 #(
        .W (3)
    ) u_sync (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .async_i ({line_reset_i, line_resume_i, line_suspend_i}),
        .sync_o  (line_s)
    );

    // While inhibited the function reacts to nothing on the bus.
    assign sus_rise = line_s[0] && !st_r.line_d[0] && !st_r.inhibit;
    assign res_rise = line_s[1] && !st_r.line_d[1] && !st_r.inhibit;
    assign rst_rise = line_s[2] && !st_r.line_d[2] && !st_r.inhibit;
    assign sof_ok   = sof_i && !st_r.inhibit;
    assign token_ok = st_r.inhibit ? '0 : iso_token_i;
    assign load_ok  = iso_load_i;

    // ------------------------------------------------------------------
    // Register access decode
    // ------------------------------------------------------------------
    logic       req;      // New request, not yet answered.
    logic       wr_lo;    // Write that carries the low byte lane.
    logic [7:0] power_rd; // Power-control read value.

    assign req   = cyc_i && stb_i && !st_r.ack;
    assign wr_lo = req && we_i && sel_i[0];

    // Reset bit reads the live bus reset signalling, not a stored bit.
    always_comb begin
        power_rd                = 8'h00;
        power_rd[PWR_ISO_GATE]  = st_r.iso_gate;
        power_rd[PWR_INHIBIT]   = st_r.inhibit;
        power_rd[PWR_RESET]     = line_s[2] && !st_r.inhibit;
        power_rd[PWR_RESUME]    = st_r.resume_drv;
        power_rd[PWR_SUSPENDED] = st_r.suspended;
        power_rd[PWR_SUSP_EN]   = st_r.susp_en;
    end

    // ------------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------------
    logic force_rst; // Software forces a whole-function reset.

    assign force_rst = wr_lo && (adr_i == ups_addr(REG_POWER_IDX)) && dat_i[PWR_RESET];

    // Bus writes come first so that hardware events later in the process win over
    // software clears in the same cycle.
    always_comb begin
        st_nxt             = st_r;
        st_nxt.line_d      = line_s;
        st_nxt.ack         = req;
        st_nxt.osc_wake    = 1'b0;
        st_nxt.func_rst    = 1'b0;
        st_nxt.bus_rst_clr = 1'b0;
        if (req) begin
            st_nxt.rdata = 32'h0000_0000;
        end

        // Register reads and writes; unmapped addresses answer with zero.
        if (req) begin
            case (adr_i)
                ups_addr(REG_POWER_IDX): begin
                    st_nxt.rdata[7:0] = power_rd;
                    if (wr_lo) begin
                        st_nxt.iso_gate = dat_i[PWR_ISO_GATE];
                        st_nxt.susp_en  = dat_i[PWR_SUSP_EN];
                        // Software may clear inhibit but never set it.
                        if (!dat_i[PWR_INHIBIT]) begin
                            st_nxt.inhibit = 1'b0;
                        end
                        // Remote wakeup starts only while suspended.
                        if (dat_i[PWR_RESUME] && st_r.suspended) begin
                            st_nxt.resume_drv = 1'b1;
                            st_nxt.osc_wake   = 1'b1;
                        end
                        // Ending the wakeup ends the suspended state.
                        if (!dat_i[PWR_RESUME] && st_r.resume_drv) begin
                            st_nxt.resume_drv = 1'b0;
                            st_nxt.suspended  = 1'b0;
                        end
                    end
                end
                ups_addr(REG_FRAME_LO_IDX): begin
                    st_nxt.rdata[7:0] = st_r.frame_lo;
                end
                ups_addr(REG_IRQ_STAT_IDX): begin
                    st_nxt.rdata[IRQ_W-1:0] = st_r.irq_stat;
                end
                ups_addr(REG_IRQ_CLR_IDX): begin
                    if (wr_lo) begin
                        st_nxt.irq_stat = st_r.irq_stat & ~dat_i[IRQ_W-1:0];
                    end
                end
                ups_addr(REG_IRQ_EN_IDX): begin
                    st_nxt.rdata[IRQ_W-1:0] = st_r.irq_en;
                    if (wr_lo) begin
                        st_nxt.irq_en = dat_i[IRQ_W-1:0];
                    end
                end
                default: begin
                    st_nxt.rdata = 32'h0000_0000;
                end
            endcase
        end

        // Frame counter advances on each accepted frame start.
        if (sof_ok) begin
            st_nxt.frame_lo = st_r.frame_lo + 8'h01;
        end

        // Suspend entry, only when detection is enabled.
        if (sus_rise && st_r.susp_en && !st_r.suspended && !res_rise && !rst_rise) begin
            st_nxt.suspended = 1'b1;
            if (st_r.irq_en[IRQ_SLEEP]) begin
                st_nxt.irq_stat[IRQ_SLEEP] = 1'b1;
            end
        end

        // Resume signalling from the host wakes the function.
        if (res_rise) begin
            if (st_r.suspended) begin
                st_nxt.osc_wake = 1'b1;
            end
            st_nxt.suspended = 1'b0;
            if (st_r.irq_en[IRQ_WAKE]) begin
                st_nxt.irq_stat[IRQ_WAKE] = 1'b1;
            end
        end

        // Bus reset: leave suspend, clear endpoints, re-enable non-suspend events.
        if (rst_rise) begin
            if (st_r.suspended) begin
                st_nxt.osc_wake = 1'b1;
            end
            st_nxt.suspended   = 1'b0;
            st_nxt.resume_drv  = 1'b0;
            st_nxt.bus_rst_clr = 1'b1;
            st_nxt.irq_en[IRQ_WAKE]     = 1'b1;
            st_nxt.irq_en[IRQ_BUSRST]   = 1'b1;
            st_nxt.irq_stat[IRQ_WAKE]   = 1'b0;
            st_nxt.irq_stat[IRQ_BUSRST] = 1'b1;
        end

        // Forced reset returns every register to default, inhibit included.
        if (force_rst) begin
            st_nxt          = ups_default();
            st_nxt.line_d   = line_s;
            st_nxt.ack      = 1'b1;
            st_nxt.func_rst = 1'b1;
            st_nxt.osc_wake = st_r.suspended;
        end

        st_nxt.irq = |(st_nxt.irq_stat & st_nxt.irq_en);
        st_nxt.traffic_en = !st_nxt.inhibit;
    end

    // Register the state; power-on reset loads the defaults.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_r <= ups_default();
        end else begin
            st_r <= st_nxt;
        end
    end

    // ------------------------------------------------------------------
    // Iso frame gate
    // ------------------------------------------------------------------
    // The gate is reset together with the function so no held packet survives.
    ups_iso_gate #(
        .N_EP (N_EP)
    ) u_iso (
        .clk_i      (clk_i),
        .rst_i      (rst_i || st_r.func_rst),
        .gate_en_i  (st_r.iso_gate),
        .sof_i      (sof_ok),
        .load_i     (load_ok),
        .token_i    (token_ok),
        .send_pkt_o (iso_send_pkt_o),
        .send_zlp_o (iso_send_zlp_o)
    );

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign dat_o             = st_r.rdata;
    assign ack_o             = st_r.ack;
    assign traffic_en_o      = st_r.traffic_en;
    assign suspended_o       = st_r.suspended;
    assign resume_drive_o    = st_r.resume_drv;
    assign osc_wake_o        = st_r.osc_wake;
    assign func_reset_o      = st_r.func_rst;
    assign bus_reset_clear_o = st_r.bus_rst_clr;
    assign irq_o             = st_r.irq;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    sequence s_force_write;
        force_rst;
    endsequence

    sequence s_reset_state;
        st_r.inhibit && func_reset_o && !st_r.suspended && !st_r.resume_drv ##1 !func_reset_o;
    endsequence

    chk_force_reset_defaults: assert property (s_force_write |=> s_reset_state)
        else $error("forced reset did not restore defaults");

    chk_inhibit_sticky: assert property (!st_r.inhibit && !force_rst |=> !st_r.inhibit)
        else $error("inhibit rose without a forced reset");

    chk_resume_exit: assert property ((res_rise && st_r.suspended && st_r.irq_en[IRQ_WAKE]
        && !force_rst) |=> (!suspended_o && st_r.irq_stat[IRQ_WAKE] ##1 irq_o))
        else $error("resume did not wake and flag the event");

    chk_wakeup_needs_susp: assert property ($rose(resume_drive_o) |-> $past(suspended_o))
        else $error("remote wakeup drive started while not suspended");

    chk_suspend_entry: assert property ((sus_rise && st_r.susp_en && !st_r.suspended
        && !res_rise && !rst_rise && !force_rst) |=> suspended_o)
        else $error("enabled suspend signalling did not suspend");

    chk_suspend_ignored: assert property ((!st_r.susp_en && !st_r.suspended)
        |=> !suspended_o)
        else $error("suspend entered with detection disabled");

    chk_bus_reset_wake: assert property ((rst_rise && st_r.suspended && !force_rst)
        |=> (!suspended_o && osc_wake_o && bus_reset_clear_o))
        else $error("bus reset did not leave suspend and wake the oscillator");

    chk_inhibit_deaf: assert property (st_r.inhibit |=> !bus_reset_clear_o && !$rose(suspended_o))
        else $error("inhibited function reacted to bus traffic");

    chk_ack_once: assert property (req |=> ack_o ##1 !ack_o)
        else $error("bus acknowledge not a single cycle after request");

    chk_irq_level: assert property (irq_o == |(st_r.irq_stat & st_r.irq_en))
        else $error("interrupt output does not match enabled status");

endmodule

// ---- verif/ups_host_model.sv ----
// Bus host model: line signalling, start-of-frame and IN tokens.
`timescale 1ns/1ns
module ups_host_model #(
    parameter int N_EP = 3  // Iso IN endpoints.
) (
    // Clock
    input  wire logic            clk_i,
    // Line levels {reset, resume, suspend}, high while signalling
    output logic      [2:0]      line_o,
    // Frame and token pulses
    output logic                 sof_o,
    output logic      [N_EP-1:0] token_o
);
    // The host starts idle, so no line state is shown before reset ends.
    initial begin
        line_o  = 3'h0;
        sof_o   = 1'b0;
        token_o = '0;
    end

    // Holds one line state for a span, then returns the line to idle.
    task automatic signal(input int which, input int cycles);
        line_o <= 3'h1 << which;
        repeat (cycles) @(posedge clk_i);
        line_o <= 3'h0;
        @(posedge clk_i);
    endtask

    // Sends a one-cycle pulse on the frame or token lines.
    task automatic pulse(input logic frame, input int ep);
        sof_o   <= frame;
        token_o <= frame ? '0 : N_EP'(1 << ep);
        @(posedge clk_i);
        sof_o   <= 1'b0;
        token_o <= '0;
        @(posedge clk_i);
    endtask
endmodule

// ---- verif/ups_power_ctrl_tb.sv ----
// Self-checking bench of the power and suspend control block.
`timescale 1ns/1ns
module ups_power_ctrl_tb;
    logic clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0;
    logic [7:0]  adr = 8'h00;
    logic [3:0]  sel = 4'h0;
    logic [31:0] dat = 32'h0, dat_o;
    logic [2:0]  line, load = 3'h0, tok, pkt, zlp;
    logic ack_o, sof, ten, susp, rdrv, irq, osc, frst, bclr;
    logic [7:0]  q[$];
    logic [7:0]  n_osc = 8'h00, n_frst = 8'h00, n_bclr = 8'h00;
    int mismatches = 0, comparisons = 0, ep;

    ups_host_model host (.clk_i(clk_i), .line_o(line), .sof_o(sof), .token_o(tok));
    ups_power_ctrl i_dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb),
        .we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(dat), .dat_o(dat_o), .ack_o(ack_o),
        .line_suspend_i(line[0]), .line_resume_i(line[1]), .line_reset_i(line[2]),
        .sof_i(sof), .iso_load_i(load), .iso_token_i(tok), .iso_send_pkt_o(pkt),
        .iso_send_zlp_o(zlp), .traffic_en_o(ten), .suspended_o(susp),
        .resume_drive_o(rdrv), .osc_wake_o(osc), .func_reset_o(frst), .bus_reset_clear_o(bclr),
        .irq_o(irq));

    initial begin
        forever #4 clk_i = ~clk_i;
    end

    // Compares a seen value with the expected one.
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp) begin
            mismatches++;
            $display("unexpected at %0t: got %h want %h", $time, seen, exp);
        end
    endtask

    // One classic cycle; a read notes its expected byte first.
    task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d);
        if (!w) q.push_back(d);
        cyc <= 1; stb <= 1; we <= w; adr <= a; dat <= {24'h0, d};
        sel <= 4'hf;
        do @(posedge clk_i); while (ack_o !== 1'b1);
        cyc <= 0; stb <= 0;
        sel <= 4'h0;
        @(posedge clk_i);
    endtask

    // Results are read data at a read ack, or an iso answer pulse.
    always @(posedge clk_i) begin
        if ((ack_o && !we) || |{pkt, zlp}) begin
            if (q.size() == 0) check(8'hff, 8'h00);
            else check(ack_o ? dat_o[7:0] : {2'h0, pkt, zlp}, q.pop_front());
        end
    end

    // Counts the one-cycle pulses that the design raises once reset has ended.
    always @(posedge clk_i) begin
        if (!rst_i) begin
            n_osc  <= n_osc + {7'h0, osc};
            n_frst <= n_frst + {7'h0, frst};
            n_bclr <= n_bclr + {7'h0, bclr};
        end
    end

    task automatic give_verdict();
        // An expected result that never appeared counts as a mismatch.
        if (q.size() != 0) mismatches++;
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    // The whole run needs under 150 cycles; this bound of 20000 cycles is generous.
    initial begin
        #160000;
        mismatches++;
        give_verdict();
    end

    initial begin
        void'($urandom(9929));
        repeat (4) @(posedge clk_i);
        rst_i <= 0;
        wb(0, 8'h04, 8'h10);
        check({7'h0, ten}, 8'h00);
        wb(1, 8'h04, 8'h08);
        wb(1, 8'h48, 8'h07);
        wb(1, 8'h04, 8'h01);
        check({7'h0, ten}, 8'h01);
        wb(1, 8'h04, 8'h11);
        wb(0, 8'h04, 8'h01);
        host.signal(0, 6);
        check({6'h0, susp, irq}, 8'h03);
        wb(0, 8'h04, 8'h03);
        wb(0, 8'h40, 8'h02);
        wb(1, 8'h44, 8'h07);
        check({7'h0, irq}, 8'h00);
        wb(1, 8'h04, 8'h05);
        check({7'h0, rdrv}, 8'h01);
        // The wakeup span is cut to a few cycles to keep the run short.
        wb(1, 8'h04, 8'h01);
        check({6'h0, susp, rdrv}, 8'h00);
        host.signal(0, 6);
        host.signal(1, 6);
        check({7'h0, susp}, 8'h00);
        wb(0, 8'h40, 8'h03);
        host.signal(0, 6);
        // The read waits until the reset level has crossed the synchroniser.
        fork
            host.signal(2, 14);
            begin
                repeat (4) @(posedge clk_i);
                wb(0, 8'h04, 8'h09);
            end
        join
        repeat (2) @(posedge clk_i);
        wb(0, 8'h04, 8'h01);
        wb(0, 8'h40, 8'h06);
        ep = $urandom % 3;
        wb(1, 8'h04, 8'h81);
        load <= 3'h1 << ep;
        @(posedge clk_i);
        load <= 3'h0;
        q.push_back(8'h1 << ep);
        host.pulse(0, ep);
        host.pulse(1, 0);
        q.push_back(8'h8 << ep);
        host.pulse(0, ep);
        wb(0, 8'h30, 8'h01);
        wb(1, 8'h04, 8'h08);
        // A bus reset while inhibited must leave the function untouched.
        fork
            host.signal(2, 14);
            begin
                repeat (4) @(posedge clk_i);
                wb(0, 8'h04, 8'h10);
            end
        join
        wb(0, 8'h40, 8'h00);
        wb(0, 8'h48, 8'h05);
        check({7'h0, ten}, 8'h00);
        check(n_osc, 8'h03);
        check(n_frst, 8'h02);
        check(n_bclr, 8'h01);
        give_verdict();
    end
endmodule
